/* File: verilog/abx_execute.sv */
// Execute unit for immediate and register add/AND, bit clear/set and bit-test skip.
// Assumes the sequencer gives one command per instruction cycle with its file operand
// already read; port operands arrive as pin levels, not latch contents.
// Summary of operation
// - Add immediate to working, flags C DC Z
// - Add working and file, flags C DC Z
// - AND immediate into working, zero flag only
// - AND working with file, zero only
// - Destination bit zero working, one file
// - Bit clear, other bits and flags kept
// - Bit set, other bits and flags kept
// - Skip next when tested bit one
// - Skip next when tested bit zero
// - Bit tests leave all flags alone
// - Port read-modify-write uses pin levels
module abx_execute (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic CMD_VALID,
	input wire abx_pkg::abx_cmd_type CMD,
	input wire logic [7:0] FILE_DATA,
	input wire logic [7:0] PIN_DATA,
	output logic [7:0] WORK,
	output abx_pkg::abx_flags_type FLAGS,
	output abx_pkg::abx_fwrite_type FILE_WRITE,
	output logic SKIP_NEXT,
	output logic EXEC_NOP
);
	// Whether the next valid command is to be thrown away
	typedef enum logic {
		SEQ_RUN,
		SEQ_DISCARD
	} abx_seq_type;

	// Registers and their next values
	abx_seq_type seq_state;
	abx_seq_type next_seq_state;
	logic [7:0] work;
	logic [7:0] next_work;
	logic carry_flag;
	logic half_flag;
	logic zero_flag;
	abx_pkg::abx_fwrite_type fwrite;
	abx_pkg::abx_fwrite_type next_fwrite;
	logic skip_flag;
	logic nop_slot;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;

	// Decode and datapath nets
	wire logic run;
	wire logic discard;
	wire logic op_add_imm;
	wire logic op_add_reg;
	wire logic op_and_imm;
	wire logic op_and_reg;
	wire logic op_bit_clear;
	wire logic op_bit_set;
	wire logic op_skip_one;
	wire logic op_skip_zero;
	wire logic is_add;
	wire logic is_and;
	wire logic is_imm;
	wire logic is_reg;
	wire logic is_bitop;
	wire logic is_test;

	wire logic to_file;
	wire logic to_work;
	wire logic arith_run;
	wire logic arith_to_work;
	wire logic arith_to_file;
	wire logic load_zero;
	wire logic load_carry;
	wire logic bit_write;

	wire logic [7:0] operand;
	wire logic [7:0] alu_b;
	wire logic [7:0] alu_result;
	wire logic alu_carry;
	wire logic alu_half;
	wire logic alu_zero;
	wire logic [7:0] bit_mask;
	wire logic [7:0] set_result;
	wire logic [7:0] clear_result;
	wire logic [7:0] bit_result;

	wire logic tested_bit;
	wire logic test_one_hit;
	wire logic test_zero_hit;
	wire logic skip_hit;
	wire logic next_carry;
	wire logic next_half;
	wire logic next_zero;
	wire logic next_skip;
	wire logic next_nop_slot;

	// Pins are asynchronous to the core clock; two stages before any use
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			pin_meta <= abx_pkg::ZERO_BYTE;
		end else begin
			pin_meta <= PIN_DATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			pin_sync <= abx_pkg::ZERO_BYTE;
		end else begin
			pin_sync <= pin_meta;
		end
	end

	// Command decode
	assign op_add_imm = (CMD.op == abx_pkg::ABX_ADD_IMMEDIATE);
	assign op_add_reg = (CMD.op == abx_pkg::ABX_ADD_REGISTER);
	assign op_and_imm = (CMD.op == abx_pkg::ABX_AND_IMMEDIATE);
	assign op_and_reg = (CMD.op == abx_pkg::ABX_AND_REGISTER);
	assign op_bit_clear = (CMD.op == abx_pkg::ABX_BIT_CLEAR);
	assign op_bit_set = (CMD.op == abx_pkg::ABX_BIT_SET);
	assign op_skip_one = (CMD.op == abx_pkg::ABX_SKIP_IF_ONE);
	assign op_skip_zero = (CMD.op == abx_pkg::ABX_SKIP_IF_ZERO);

	assign is_add = op_add_imm || op_add_reg;
	assign is_and = op_and_imm || op_and_reg;
	assign is_imm = op_add_imm || op_and_imm;
	assign is_reg = op_add_reg || op_and_reg;
	assign is_bitop = op_bit_clear || op_bit_set;
	assign is_test = op_skip_one || op_skip_zero;

	// A command landing in a skipped slot is discarded and becomes a no-op
	assign discard = CMD_VALID && (seq_state == SEQ_DISCARD);
	assign run = CMD_VALID && (seq_state == SEQ_RUN);

	// Ports read pins so an input driven low writes back low
	assign operand = CMD.is_port ? pin_sync : FILE_DATA;
	assign alu_b = is_imm ? CMD.literal : operand;

	// Immediate forms always target the working register; dest is ignored
	assign to_file = is_reg && (CMD.dest == abx_pkg::DEST_FILE);
	assign to_work = !to_file;
	assign arith_run = run && (is_add || is_and);
	assign arith_to_work = arith_run && to_work;
	assign arith_to_file = arith_run && to_file;
	assign load_zero = arith_run;
	assign load_carry = run && is_add;

	// One mask bit per position of the byte
	for (genvar i = 0; i < 8; i++) begin : g_bit
		localparam logic [2:0] POS = 3'(i);
		assign bit_mask[i] = (CMD.bit_sel == POS);
		assign set_result[i] = operand[i] || bit_mask[i];
		assign clear_result[i] = operand[i] && !bit_mask[i];
	end
	assign bit_result = op_bit_set ? set_result : clear_result;
	assign bit_write = run && is_bitop;

	// Bit tests read the same operand as the bit edits
	assign tested_bit = operand[CMD.bit_sel];
	assign test_one_hit = op_skip_one && tested_bit;
	assign test_zero_hit = op_skip_zero && !tested_bit;
	assign skip_hit = run && is_test && (test_one_hit || test_zero_hit);

	// Shared adder and AND for all four arithmetic forms
	abx_alu #(
		.WIDTH(abx_pkg::DATA_W)
	) abx_alu_inst (
		.a(work),
		.b(alu_b),
		.do_and(is_and),
		.result(alu_result),
		.carry(alu_carry),
		.half_carry(alu_half),
		.zero(alu_zero)
	);

	// Skip state holds across idle cycles until a valid command arrives
	always_comb begin
		next_seq_state = seq_state;
		unique case (seq_state)
			SEQ_RUN: begin
				if (skip_hit) begin
					next_seq_state = SEQ_DISCARD;
				end
			end
			SEQ_DISCARD: begin
				if (CMD_VALID) begin
					next_seq_state = SEQ_RUN;
				end
			end
		endcase
	end

	// Skip and no-op flags
	assign next_skip = (next_seq_state == SEQ_DISCARD);
	assign next_nop_slot = discard;

	always_comb begin
		next_work = work;
		if (arith_to_work) begin
			next_work = alu_result;
		end
	end

	// AND keeps carry and half-carry; bit ops and tests touch no flag
	assign next_carry = load_carry ? alu_carry : carry_flag;
	assign next_half = load_carry ? alu_half : half_flag;
	assign next_zero = load_zero ? alu_zero : zero_flag;

	// One-cycle write pulse; the address simply follows the command
	always_comb begin
		next_fwrite = '0;
		next_fwrite.addr = CMD.addr;
		if (arith_to_file) begin
			next_fwrite.write = 1'h1;
			next_fwrite.data = alu_result;
		end else if (bit_write) begin
			next_fwrite.write = 1'h1;
			next_fwrite.data = bit_result;
		end
	end

	// State registers
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			seq_state <= SEQ_RUN;
		end else begin
			seq_state <= next_seq_state;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			work <= abx_pkg::W_RESET;
		end else begin
			work <= next_work;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			carry_flag <= 1'h0;
		end else begin
			carry_flag <= next_carry;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			half_flag <= 1'h0;
		end else begin
			half_flag <= next_half;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			zero_flag <= 1'h0;
		end else begin
			zero_flag <= next_zero;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			skip_flag <= 1'h0;
		end else begin
			skip_flag <= next_skip;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			fwrite <= '0;
		end else begin
			fwrite <= next_fwrite;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			nop_slot <= 1'h0;
		end else begin
			nop_slot <= next_nop_slot;
		end
	end

	// Every output comes straight from a register
	assign WORK = work;
	assign FLAGS = '{carry: carry_flag, half_carry: half_flag, zero: zero_flag};
	assign FILE_WRITE = fwrite;
	assign SKIP_NEXT = skip_flag;
	assign EXEC_NOP = nop_slot;
endmodule : abx_execute

/* File: shared/abx_pkg.sv */
// Package for the add and bit-operation execute unit.
// Assumes an 8-bit datapath with a 7-bit file address and one core clock.
package abx_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BITSEL_W = 3;
	localparam int HALF_BIT = 4;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic DEST_W = 1'h0;
	localparam logic DEST_FILE = 1'h1;

	typedef enum logic [3:0] {
		ABX_NONE,
		ABX_ADD_IMMEDIATE,
		ABX_ADD_REGISTER,
		ABX_AND_IMMEDIATE,
		ABX_AND_REGISTER,
		ABX_BIT_CLEAR,
		ABX_BIT_SET,
		ABX_SKIP_IF_ONE,
		ABX_SKIP_IF_ZERO
	} abx_op_type;

	typedef struct packed {
		abx_op_type op;
		logic [7:0] literal;
		logic [6:0] addr;
		logic dest;
		logic [2:0] bit_sel;
		logic is_port;
	} abx_cmd_type;

	typedef struct packed {
		logic carry;
		logic half_carry;
		logic zero;
	} abx_flags_type;

	typedef struct packed {
		logic write;
		logic [6:0] addr;
		logic [7:0] data;
	} abx_fwrite_type;
endpackage : abx_pkg

/* File: verilog/abx_alu.sv */
// Combinational add and AND of two bytes with flag generation.
// Assumes operands are stable within the cycle; no state is held here.
module abx_alu #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] a,
	input wire logic [WIDTH-1:0] b,
	input wire logic do_and,
	output logic [WIDTH-1:0] result,
	output logic carry,
	output logic half_carry,
	output logic zero
);
	wire logic [WIDTH:0] sum;
	wire logic [abx_pkg::HALF_BIT:0] low_sum;

	assign sum = {1'h0, a} + {1'h0, b};
	assign low_sum = {1'h0, a[abx_pkg::HALF_BIT-1:0]} + {1'h0, b[abx_pkg::HALF_BIT-1:0]};
	assign result = do_and ? (a & b) : sum[WIDTH-1:0];
	assign carry = sum[WIDTH];
	assign half_carry = low_sum[abx_pkg::HALF_BIT];
	assign zero = (result == '0);
endmodule : abx_alu

/* File: tb/abx_execute_asserts.sv */
// Port checker for the execute unit.
// Assumes op numbers follow the package enum order.
module abx_chk (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic CMD_VALID,
	input wire logic SKIP_NEXT,
	input wire logic EXEC_NOP,
	input wire logic [7:0] FILE_DATA,
	input wire logic [7:0] PIN_DATA,
	input wire logic [7:0] WORK,
	input wire abx_pkg::abx_cmd_type CMD,
	input wire abx_pkg::abx_flags_type FLAGS,
	input wire abx_pkg::abx_fwrite_type FILE_WRITE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// Pin levels reach the unit through two stages
	logic [7:0] pin_q1;
	logic [7:0] pin_q2;
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			pin_q1 <= 8'h00;
			pin_q2 <= 8'h00;
		end else begin
			pin_q1 <= PIN_DATA;
			pin_q2 <= pin_q1;
		end
	end
	wire [3:0] o = CMD_VALID && !SKIP_NEXT ? CMD.op : 4'h0;
	wire [7:0] v = CMD.is_port ? pin_q2 : FILE_DATA;
	wire [8:0] s = {1'h0, WORK} + {1'h0, v};
	wire [7:0] s_lo = s[7:0];
	wire s_c = s[8];
	wire b = v[CMD.bit_sel];
	wire [7:0] clr_v = v & ~(8'h01 << CMD.bit_sel);
	wire [7:0] set_v = v | (8'h01 << CMD.bit_sel);
	add_imm_a: assert property (o == 1 |=> WORK == $past(WORK) + $past(CMD.literal))
		else $error("add");
	add_reg_a: assert property (o == 2 && CMD.dest |=> FILE_WRITE.data == $past(s_lo) && FLAGS.carry == $past(s_c))
		else $error("add reg");
	and_imm_a: assert property (o == 3 |=> WORK == ($past(WORK) & $past(CMD.literal)) && FLAGS.zero == (WORK == 8'h00))
		else $error("and");
	and_reg_a: assert property (o == 4 && !CMD.dest |=> WORK == ($past(WORK) & $past(v)) && !FILE_WRITE.write)
		else $error("and reg");
	bit_clr_a: assert property (o == 5 |=> FILE_WRITE.write && FILE_WRITE.data == $past(clr_v))
		else $error("clear");
	bit_set_a: assert property (o == 6 |=> FILE_WRITE.write && FILE_WRITE.data == $past(set_v) && $stable(FLAGS))
		else $error("set");
	skip_one_a: assert property (o == 7 |=> SKIP_NEXT == $past(b) && $stable(FLAGS))
		else $error("skip one");
	skip_zero_a: assert property (o == 8 |=> SKIP_NEXT != $past(b))
		else $error("skip zero");
	skip_drop_a: assert property (CMD_VALID && SKIP_NEXT |=> EXEC_NOP && !FILE_WRITE.write && $stable(WORK) && $stable(FLAGS))
		else $error("drop");
endmodule : abx_chk
bind abx_execute abx_chk abx_chk_inst(.CLOCK, .NRST, .CMD_VALID, .SKIP_NEXT, .EXEC_NOP, .FILE_DATA, .PIN_DATA,
	.WORK, .CMD, .FLAGS, .FILE_WRITE);

/* File: tb/abx_fmem.sv */
// File register model.
// Assumes one-cycle write pulses.
module abx_fmem (
	input wire logic clock,
	input wire abx_pkg::abx_fwrite_type fw,
	input wire logic [6:0] addr,
	output logic [7:0] data
);
	logic [7:0] mem [128] = '{default: 8'h00};
	always @(posedge clock) if (fw.write) mem[fw.addr] <= fw.data;
	// Forward so back-to-back ops see it
	assign data = fw.write && fw.addr == addr ? fw.data : mem[addr];
endmodule : abx_fmem

/* File: tb/test_add_and_bit_ops_execute.sv */
// Bench for the execute unit.
// Assumes the file model and bound checker.
module test_add_and_bit_ops_execute;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK = 0, NRST = 0, CMD_VALID = 0, SKIP_NEXT, EXEC_NOP;
	logic [7:0] FILE_DATA, PIN_DATA = 8'h5A, WORK;
	abx_pkg::abx_cmd_type CMD = '0;
	abx_pkg::abx_flags_type FLAGS;
	abx_pkg::abx_fwrite_type FILE_WRITE;
	int failures = 0, n_tests = 0;
	abx_execute abx_execute_inst(.CLOCK, .NRST, .CMD_VALID, .CMD, .FILE_DATA, .PIN_DATA, .WORK, .FLAGS,
		.FILE_WRITE, .SKIP_NEXT, .EXEC_NOP);
	abx_fmem abx_fmem_inst(.clock(CLOCK), .fw(FILE_WRITE), .addr(CMD.addr), .data(FILE_DATA));
	initial forever #25 CLOCK = ~CLOCK;
	task chk(string n, logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// k: literal, bit [2:0], dest [3], port [4]
	task run(int o, logic [7:0] k);
		CMD = '{abx_pkg::abx_op_type'(o), k, 7'h7F, k[3], k[2:0], k[4]};
		CMD_VALID = 1;
		@(posedge CLOCK);
		#1;
	endtask : run
	task t_arith;
		run(1, 8'hF8);
		run(1, 8'h0F);
		chk("add", {WORK, FLAGS}, 11'h03E);
		run(3, 8'h08);
		chk("and", {WORK, FLAGS}, 11'h007);
	endtask : t_arith
	task t_reg;
		run(6, 8'h07);
		chk("set", FILE_WRITE, 16'hFF80);
		run(2, 8'h00);
		run(2, 8'h08);
		chk("addf", {FILE_WRITE, FLAGS}, 19'h7F805);
		run(4, 8'h00);
		chk("andw", {FILE_WRITE.write, WORK}, 9'h000);
		run(5, 8'h11);
		chk("clr", FILE_WRITE, 16'hFF58);
	endtask : t_reg
	task t_skip;
		run(7, 8'h03);
		chk("skp", {SKIP_NEXT, FLAGS}, 4'hD);
		run(1, 8'h01);
		chk("nop", {EXEC_NOP, SKIP_NEXT, WORK}, 10'h200);
		run(8, 8'h00);
		run(6, 8'h00);
		chk("nop", {EXEC_NOP, FILE_WRITE.write}, 2'h2);
		run(7, 8'h00);
		chk("skp", SKIP_NEXT, 1'b0);
		run(0, 8'hFF);
		chk("none", {FILE_WRITE.write, SKIP_NEXT, WORK, FLAGS}, 13'h0005);
	endtask : t_skip
	task complete_run;
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial begin
		repeat (12) @(posedge CLOCK);
		#1 NRST = 1;
		chk("rst", {WORK, FLAGS, FILE_WRITE, SKIP_NEXT}, 28'h0);
		t_arith;
		t_reg;
		t_skip;
		complete_run;
	end
endmodule : test_add_and_bit_ops_execute
